// >>> include/phy_an_consts.svh
// register offsets, field positions, reset values and timing counts
// for the auto-negotiation and duplex control block.
// assumes a 100 MHz reference clock.
`ifndef PHY_AN_CONSTS_SVH
`define PHY_AN_CONSTS_SVH

// ----------------------------------------------------------------
// management register offsets
// ----------------------------------------------------------------
`define REG_CTRL 5'h00
`define REG_STAT 5'h01
`define REG_EVENT 5'h02
`define REG_RDCLR 5'h03
`define REG_LEDCFG 5'h04

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_SOFT_RST_BIT 15
`define CTRL_SPEED_BIT 13
`define CTRL_AN_EN_BIT 12
`define CTRL_RESTART_BIT 9
`define CTRL_DUPLEX_BIT 8
`define CTRL_SPEED_RST 1'b1
`define CTRL_AN_EN_RST 1'b1
`define CTRL_DUPLEX_RST 1'b0

// ----------------------------------------------------------------
// status, event and read-to-clear fields
// ----------------------------------------------------------------
`define STAT_JABBER_BIT 1
`define STAT_LINK_BIT 2
`define STAT_AN_ABLE_BIT 3
`define STAT_AN_DONE_BIT 5
`define EVT_LINK_DOWN_BIT 0
`define EVT_RESTART_BIT 1
`define RDCLR_AN_DONE_BIT 0
`define LED_MODE_RST 2'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define REF_CLK_PERIOD_NS 10
`define BREAK_LINK_MS 1200
`define BREAK_LINK_CYC ((`BREAK_LINK_MS * 64'd1000000) / `REF_CLK_PERIOD_NS)

`endif

// >>> include/phy_an_pkg.sv
// types shared by the auto-negotiation and duplex control block.
// assumes nothing of its surroundings.
package phy_an_pkg;

    // ----------------------------------------------------------------
    // control state
    // ----------------------------------------------------------------
    typedef enum logic [3:0]
    {
        ST_BREAK = 4'b0001,
        ST_NEGOT = 4'b0010,
        ST_LINKED = 4'b0100,
        ST_FORCED = 4'b1000
    } an_state_t;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic speed100;
        logic full_duplex;
    } link_mode_t;

    typedef struct packed
    {
        logic tx_act;
        logic rx_act;
    } line_act_t;

    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [4:0] addr;
        logic [15:0] wdata;
    } mgmt_req_t;

endpackage

// >>> rtl/phy_an_ctrl.sv
// auto-negotiation restart, forced mode and duplex carrier control,
// with a small management register set reached through plain ports.
// assumes all inputs are synchronous to ref_clk; the negotiation engine
// and line front end sit outside and are steered through an_run/line_quiet.
`timescale 1ns/1ps
`include "phy_an_consts.svh"

module phy_an_ctrl
    import phy_an_pkg::*;
#(
    parameter int unsigned BREAK_LINK_CYC = 32'(`BREAK_LINK_CYC)
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // management access
    input wire mgmt_req_t mgmt,
    output logic [15:0] mgmt_rdata,
    // negotiation engine
    input wire logic an_done,
    input wire link_mode_t an_result,
    output logic an_run,
    // line status and activity
    input wire logic link_ok,
    input wire logic jabber,
    input wire line_act_t act,
    output logic line_quiet,
    // resolved mode and carrier
    output link_mode_t op_mode,
    output logic crs,
    output logic col,
    output logic [1:0] led_mode
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    an_state_t state_r;
    an_state_t state_nxt;
    logic [26:0] brk_cnt_r;
    logic brk_done;
    logic an_en_r;
    logic speed_r;
    logic duplex_r;
    logic restart_r;
    logic soft_rst_r;
    logic link_ll_r;
    logic jabber_lh_r;
    logic evt_link_down_r;
    logic evt_restart_r;
    logic rc_an_done_r;
    logic [1:0] led_mode_r;
    link_mode_t op_mode_r;
    logic crs_r;
    logic col_r;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic ctrl_wr;
    logic restart_cmd;
    logic stat_rd;
    logic link_drop;

    assign ctrl_wr = mgmt.wr && (mgmt.addr == `REG_CTRL);
    assign restart_cmd = ctrl_wr && mgmt.wdata[`CTRL_RESTART_BIT]
        && mgmt.wdata[`CTRL_AN_EN_BIT];
    assign stat_rd = mgmt.rd && (mgmt.addr == `REG_STAT);
    assign brk_done = (brk_cnt_r >= 27'(BREAK_LINK_CYC - 1));
    assign link_drop = (state_r == ST_LINKED) && !link_ok;

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    // soft reset is a one-cycle pulse so the bit reads back as zero
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            soft_rst_r <= 1'b0;
        else
            soft_rst_r <= ctrl_wr && mgmt.wdata[`CTRL_SOFT_RST_BIT];
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            an_en_r <= `CTRL_AN_EN_RST;
            speed_r <= `CTRL_SPEED_RST;
            duplex_r <= `CTRL_DUPLEX_RST;
        end
        else if (soft_rst_r || ctrl_wr)
        begin
            an_en_r <= soft_rst_r ? `CTRL_AN_EN_RST : mgmt.wdata[`CTRL_AN_EN_BIT];
            speed_r <= soft_rst_r ? `CTRL_SPEED_RST : mgmt.wdata[`CTRL_SPEED_BIT];
            duplex_r <= soft_rst_r ? `CTRL_DUPLEX_RST : mgmt.wdata[`CTRL_DUPLEX_BIT];
        end
    end

    // the set from a fresh write wins over the self-clear
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            restart_r <= 1'b0;
        else if (restart_cmd && !soft_rst_r)
            restart_r <= 1'b1;
        else if (soft_rst_r || state_r == ST_BREAK)
            restart_r <= 1'b0;
    end

    // survives soft reset: only the pin reset touches it
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            led_mode_r <= `LED_MODE_RST;
        else if (mgmt.wr && (mgmt.addr == `REG_LEDCFG))
            led_mode_r <= mgmt.wdata[1:0];
    end

    // ----------------------------------------------------------------
    // restart state machine
    // ----------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_BREAK:
                if (brk_done)
                    state_nxt = ST_NEGOT;
            ST_NEGOT:
                if (an_done)
                    state_nxt = ST_LINKED;
            ST_LINKED:
                if (!link_ok)
                    state_nxt = ST_NEGOT;
            ST_FORCED:
                state_nxt = ST_NEGOT;
            default:
                state_nxt = ST_NEGOT;
        endcase
        if (!an_en_r)
            state_nxt = ST_FORCED;
        if (restart_cmd)
            state_nxt = ST_BREAK;
        if (soft_rst_r)
            state_nxt = ST_NEGOT;
    end

    // negotiation is enabled by default, so reset goes straight to it
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            state_r <= ST_NEGOT;
        else
            state_r <= state_nxt;
    end

    // a restart during the break period starts the wait over
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            brk_cnt_r <= 27'h0000000;
        else if (state_r != ST_BREAK || restart_cmd)
            brk_cnt_r <= 27'h0000000;
        else if (!brk_done)
            brk_cnt_r <= brk_cnt_r + 27'h0000001;
    end

    assign an_run = (state_r == ST_NEGOT);
    assign line_quiet = (state_r == ST_BREAK);

    // ----------------------------------------------------------------
    // operating mode and carrier
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            op_mode_r.speed100 <= `CTRL_SPEED_RST;
            op_mode_r.full_duplex <= `CTRL_DUPLEX_RST;
        end
        else if (!an_en_r)
        begin
            op_mode_r.speed100 <= speed_r;
            op_mode_r.full_duplex <= duplex_r;
        end
        else if (state_r == ST_NEGOT && an_done)
            op_mode_r <= an_result;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            crs_r <= 1'b0;
            col_r <= 1'b0;
        end
        else if (line_quiet || restart_cmd)
        begin
            crs_r <= 1'b0;
            col_r <= 1'b0;
        end
        else if (op_mode_r.full_duplex)
        begin
            crs_r <= act.rx_act;
            col_r <= 1'b0;
        end
        else
        begin
            crs_r <= act.tx_act || act.rx_act;
            col_r <= act.tx_act && act.rx_act;
        end
    end

    // ----------------------------------------------------------------
    // latched status, events and read-to-clear
    // ----------------------------------------------------------------
    // a low link latches low; the read re-arms it with the live level
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            link_ll_r <= 1'b0;
            jabber_lh_r <= 1'b0;
        end
        else
        begin
            if (soft_rst_r || !link_ok)
                link_ll_r <= 1'b0;
            else if (stat_rd)
                link_ll_r <= 1'b1;
            if (jabber && !soft_rst_r)
                jabber_lh_r <= 1'b1;
            else if (stat_rd || soft_rst_r)
                jabber_lh_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            evt_link_down_r <= 1'b0;
            evt_restart_r <= 1'b0;
        end
        else
        begin
            if (link_drop && !soft_rst_r)
                evt_link_down_r <= 1'b1;
            else if (soft_rst_r || (mgmt.wr && mgmt.addr == `REG_EVENT
                && mgmt.wdata[`EVT_LINK_DOWN_BIT]))
                evt_link_down_r <= 1'b0;
            if (state_r == ST_BREAK && brk_done && !soft_rst_r)
                evt_restart_r <= 1'b1;
            else if (soft_rst_r || (mgmt.wr && mgmt.addr == `REG_EVENT
                && mgmt.wdata[`EVT_RESTART_BIT]))
                evt_restart_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rc_an_done_r <= 1'b0;
        else if (state_r == ST_NEGOT && an_done && !soft_rst_r)
            rc_an_done_r <= 1'b1;
        else if (soft_rst_r || (mgmt.rd && mgmt.addr == `REG_RDCLR))
            rc_an_done_r <= 1'b0;
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    // status takes no write path at all; unmapped offsets read zero
    always_comb
    begin
        rdata_nxt = 16'h0000;
        case (mgmt.addr)
            `REG_CTRL:
            begin
                rdata_nxt[`CTRL_SPEED_BIT] = speed_r;
                rdata_nxt[`CTRL_AN_EN_BIT] = an_en_r;
                rdata_nxt[`CTRL_RESTART_BIT] = restart_r;
                rdata_nxt[`CTRL_DUPLEX_BIT] = duplex_r;
            end
            `REG_STAT:
            begin
                rdata_nxt[`STAT_JABBER_BIT] = jabber_lh_r;
                rdata_nxt[`STAT_LINK_BIT] = link_ll_r;
                rdata_nxt[`STAT_AN_ABLE_BIT] = 1'b1;
                rdata_nxt[`STAT_AN_DONE_BIT] = (state_r == ST_LINKED);
            end
            `REG_EVENT:
            begin
                rdata_nxt[`EVT_LINK_DOWN_BIT] = evt_link_down_r;
                rdata_nxt[`EVT_RESTART_BIT] = evt_restart_r;
            end
            `REG_RDCLR:
                rdata_nxt[`RDCLR_AN_DONE_BIT] = rc_an_done_r;
            default:
                rdata_nxt = 16'h0000;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rdata_r <= 16'h0000;
        else if (mgmt.rd)
            rdata_r <= rdata_nxt;
    end

    assign mgmt_rdata = rdata_r;
    assign op_mode = op_mode_r;
    assign crs = crs_r;
    assign col = col_r;
    assign led_mode = led_mode_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    restart_enters_break_a: assert property (restart_cmd && !soft_rst_r
        |=> state_r == ST_BREAK && restart_r)
        else $error("restart write did not enter break");
    link_loss_resume_a: assert property (link_drop && an_en_r && !mgmt.wr
        && !soft_rst_r |=> state_r == ST_NEGOT)
        else $error("link loss did not resume negotiation");
    break_silences_line_a: assert property (state_r == ST_BREAK
        |-> line_quiet && !an_run ##1 !crs && !col)
        else $error("line active during break");
    break_timer_hold_a: assert property (state_r == ST_BREAK && !brk_done
        && !soft_rst_r && !ctrl_wr |=> state_r == ST_BREAK)
        else $error("break left before timer expired");
    break_exit_a: assert property ($past(state_r) == ST_BREAK
        && state_r == ST_NEGOT && !$past(soft_rst_r) |-> $past(brk_done))
        else $error("negotiation resumed early");
    an_disable_forced_a: assert property (!an_en_r && !ctrl_wr
        && !soft_rst_r |=> state_r == ST_FORCED)
        else $error("disabled negotiation not forced");
    forced_mode_a: assert property (!an_en_r ##1 !an_en_r |->
        op_mode.speed100 == $past(speed_r)
        && op_mode.full_duplex == $past(duplex_r))
        else $error("forced mode not taken from control bits");
    an_mode_ignores_bits_a: assert property (an_en_r && $past(an_en_r)
        && !(state_r == ST_NEGOT && an_done) |=> $stable(op_mode))
        else $error("mode changed without negotiation");
    half_carrier_a: assert property (!op_mode.full_duplex && !line_quiet
        && !restart_cmd |=> crs == $past(act.tx_act || act.rx_act)
        && col == $past(act.tx_act && act.rx_act))
        else $error("half duplex carrier or collision wrong");
    full_carrier_a: assert property (op_mode.full_duplex && !line_quiet
        && !restart_cmd |=> crs == $past(act.rx_act) && !col)
        else $error("full duplex carrier or collision wrong");
    wo_reads_zero_a: assert property (mgmt.rd && mgmt.addr == `REG_LEDCFG
        |=> mgmt_rdata == 16'h0000)
        else $error("write-only register read nonzero");
    w1c_clear_a: assert property (evt_link_down_r && mgmt.wr
        && mgmt.addr == `REG_EVENT && mgmt.wdata[`EVT_LINK_DOWN_BIT]
        && !link_drop |=> !evt_link_down_r)
        else $error("write one did not clear event");
    rc_clear_a: assert property (mgmt.rd && mgmt.addr == `REG_RDCLR
        && !(state_r == ST_NEGOT && an_done) |=> !rc_an_done_r
        && mgmt_rdata[`RDCLR_AN_DONE_BIT] == $past(rc_an_done_r))
        else $error("read-to-clear misbehaved");
    latch_hold_a: assert property (!link_ll_r && !stat_rd
        |=> !link_ll_r)
        else $error("latched link low released without read");
    soft_reset_keep_a: assert property (soft_rst_r && !mgmt.wr
        |=> $stable(led_mode) && an_en_r == `CTRL_AN_EN_RST
        && state_r == ST_NEGOT)
        else $error("soft reset handling wrong");
    self_clear_a: assert property (state_r == ST_BREAK && !restart_cmd
        |=> !restart_r)
        else $error("restart bit did not self-clear");

    restart_cycle_c: cover property (restart_cmd ##1 state_r == ST_BREAK
        ##[1:20] state_r == ST_NEGOT);
    link_drop_c: cover property (state_r == ST_LINKED ##1 link_drop);
    half_collision_c: cover property (col);
    forced_c: cover property (state_r == ST_FORCED && op_mode.full_duplex);

endmodule // phy_an_ctrl

// >>> testbench/link_partner_model.sv
// behavioural model of the remote link partner and negotiation engine
// seen from the control block: answers negotiation, drives link presence.
// assumes an_run and line_quiet come from the control block on ref_clk.
`timescale 1ns/1ps

module link_partner_model
    import phy_an_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // behaviour chosen by the bench
    input wire logic cable_ok,
    input wire link_mode_t adv_mode,
    input wire logic [7:0] answer_dly,
    // device side
    input wire logic an_run,
    input wire logic line_quiet,
    output logic an_done,
    output link_mode_t an_result,
    output logic link_ok
);
    logic [7:0] wait_r;

    // ----------------------------------------------------------------
    // negotiation answer
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wait_r <= 8'h00;
            an_done <= 1'b0;
        end
        else
        begin
            an_done <= 1'b0;
            if (!an_run || an_done || !link_ok)
                wait_r <= 8'h00;
            else if (wait_r >= answer_dly)
            begin
                an_done <= 1'b1;
                wait_r <= 8'h00;
            end
            else
                wait_r <= wait_r + 8'h01;
        end
    end

    // result is only valid with the pulse; garbage otherwise so nothing leans on it
    assign an_result = an_done ? adv_mode : ~adv_mode;
    // partner loses our signal during the break wait and drops its own too
    assign link_ok = cable_ok && !line_quiet;
endmodule // link_partner_model

// >>> testbench/tb_top.sv
// self-checking bench for the auto-negotiation and duplex control block.
// assumes the package is compiled first; break-link count is shortened.
`timescale 1ns/1ps

module tb_top
    import phy_an_pkg::*;
;
    localparam int BLC = 16;

    typedef struct packed
    {
        logic [15:0] ctrl;
        logic tx;
        logic rx;
        link_mode_t mode;
        logic crs;
        logic col;
    } duplex_row_t;

    // forced modes: reserved bits written as zero
    localparam duplex_row_t ROWS [7] = '{
        '{16'h0000, 1'b1, 1'b1, 2'b00, 1'b1, 1'b1},
        '{16'h0000, 1'b1, 1'b0, 2'b00, 1'b1, 1'b0},
        '{16'h0000, 1'b0, 1'b1, 2'b00, 1'b1, 1'b0},
        '{16'h2000, 1'b0, 1'b0, 2'b10, 1'b0, 1'b0},
        '{16'h0100, 1'b1, 1'b1, 2'b01, 1'b1, 1'b0},
        '{16'h2100, 1'b1, 1'b0, 2'b11, 1'b0, 1'b0},
        '{16'h2100, 1'b0, 1'b1, 2'b11, 1'b1, 1'b0}
    };

    logic ref_clk;
    logic rst;
    mgmt_req_t mgmt;
    logic [15:0] mgmt_rdata;
    logic an_done;
    link_mode_t an_result;
    logic an_run;
    logic link_ok;
    logic jabber;
    line_act_t act;
    logic line_quiet;
    link_mode_t op_mode;
    logic crs;
    logic col;
    logic [1:0] led_mode;
    logic cable_ok;
    logic [15:0] rd_v;
    int num_errors;
    int n_checks;
    int n;

    phy_an_ctrl #(.BREAK_LINK_CYC(BLC)) dut_u (.ref_clk(ref_clk), .rst(rst), .mgmt(mgmt),
        .mgmt_rdata(mgmt_rdata), .an_done(an_done), .an_result(an_result), .an_run(an_run),
        .link_ok(link_ok), .jabber(jabber), .act(act), .line_quiet(line_quiet),
        .op_mode(op_mode), .crs(crs), .col(col), .led_mode(led_mode));

    link_partner_model partner_u (.ref_clk(ref_clk), .rst(rst), .cable_ok(cable_ok),
        .adv_mode(2'b11), .answer_dly(8'h14), .an_run(an_run), .line_quiet(line_quiet),
        .an_done(an_done), .an_result(an_result), .link_ok(link_ok));

    always #5 ref_clk = ~ref_clk;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask

    // only mapped offsets are ever written: reserved locations stay untouched
    task automatic wr(input logic [4:0] addr, input logic [15:0] data);
        @(posedge ref_clk);
        mgmt <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge ref_clk);
        mgmt <= '0;
        #1;
    endtask

    task automatic rd(input logic [4:0] addr, output logic [15:0] data);
        @(posedge ref_clk);
        mgmt <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
        @(posedge ref_clk);
        mgmt <= '0;
        @(posedge ref_clk);
        #1;
        data = mgmt_rdata;
    endtask

    // sel 0: an_run equals v[0]; sel 1: op_mode equals v
    task automatic wait_for(input int sel, input logic [1:0] v);
        int i;
        for (i = 0; i < 300; i++)
        begin
            if ((sel == 0 && an_run === v[0]) || (sel == 1 && op_mode === v))
                return;
            @(posedge ref_clk);
            #1;
        end
        $display("ERROR wait %0d expected %h seen timeout", sel, v);
        num_errors++;
        give_verdict();
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        rst = 1'b1;
        mgmt = '0;
        jabber = 1'b0;
        act = '0;
        cable_ok = 1'b1;
        num_errors = 0;
        n_checks = 0;
        do_reset();
        check("an_run", 16'h1, an_run);
        check("op_mode", 16'h2, op_mode);
        check("quiet crs col led", 16'h0, {line_quiet, crs, col, led_mode});
        rd(5'h00, rd_v);
        check("ctrl", 16'h3000, rd_v & 16'hB300);
        wait_for(0, 2'b00);
        @(posedge ref_clk);
        #1;
        check("op_mode neg", 16'h3, op_mode);
        rd(5'h01, rd_v);
        check("status", 16'h0028, rd_v & 16'h0028);
        rd(5'h03, rd_v);
        check("rdclr first", 16'h1, rd_v & 16'h0001);
        rd(5'h03, rd_v);
        check("rdclr second", 16'h0, rd_v & 16'h0001);
        wr(5'h01, 16'h0000);
        rd(5'h01, rd_v);
        check("status ro", 16'h0028, rd_v & 16'h0028);
        wr(5'h04, 16'h0003);
        rd(5'h04, rd_v);
        check("led read", 16'h0000, rd_v);
        check("led_mode", 16'h3, led_mode);
        @(posedge ref_clk);
        jabber <= 1'b1;
        @(posedge ref_clk);
        jabber <= 1'b0;
        rd(5'h01, rd_v);
        check("jabber latched", 16'h2, rd_v & 16'h0002);
        rd(5'h01, rd_v);
        check("jabber cleared", 16'h0, rd_v & 16'h0002);

        // link loss goes straight back to negotiation, link bit latches low
        @(posedge ref_clk);
        cable_ok <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check("an_run loss", 16'h1, an_run);
        cable_ok <= 1'b1;
        rd(5'h02, rd_v);
        check("event down", 16'h1, rd_v & 16'h0001);
        rd(5'h01, rd_v);
        check("link latched", 16'h0, rd_v & 16'h0004);
        rd(5'h01, rd_v);
        check("link rearmed", 16'h4, rd_v & 16'h0004);
        wr(5'h02, 16'h0001);
        rd(5'h02, rd_v);
        check("event w1c", 16'h0, rd_v & 16'h0001);
        wait_for(0, 2'b00);

        // software restart with traffic on the line, full duplex negotiated
        @(posedge ref_clk);
        act <= '{tx_act: 1'b1, rx_act: 1'b1};
        wr(5'h00, 16'h1200);
        check("line_quiet", 16'h1, line_quiet);
        check("crs col quiet", 16'h0, {crs, col});
        n = 0;
        while (line_quiet === 1'b1 && n < 100)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n < BLC || n > BLC + 1)
        begin
            $display("ERROR break wait expected %0d seen %0d", BLC, n);
            num_errors++;
        end
        n_checks++;
        check("an_run break", 16'h1, an_run);
        act <= '0;
        rd(5'h00, rd_v);
        check("restart cleared", 16'h0, rd_v & 16'h0200);
        rd(5'h02, rd_v);
        check("event restart", 16'h2, rd_v & 16'h0002);
        wr(5'h02, 16'h0000);
        rd(5'h02, rd_v);
        check("event w0 keeps", 16'h2, rd_v & 16'h0002);
        wr(5'h02, 16'h0002);
        rd(5'h02, rd_v);
        check("event w1 clears", 16'h0, rd_v & 16'h0002);

        // ----------------------------------------------------------------
        // forced modes and carrier behaviour
        // ----------------------------------------------------------------
        foreach (ROWS[i])
        begin
            wr(5'h00, ROWS[i].ctrl);
            wait_for(1, ROWS[i].mode);
            check("op_mode forced", ROWS[i].mode, op_mode);
            @(posedge ref_clk);
            act <= '{tx_act: ROWS[i].tx, rx_act: ROWS[i].rx};
            repeat (2) @(posedge ref_clk);
            #1;
            check("crs", ROWS[i].crs, crs);
            check("col", ROWS[i].col, col);
            act <= '0;
        end
        check("an_run off", 16'h0, an_run);

        // re-enable with mode bits opposite to the partner's answer
        wr(5'h00, 16'h1000);
        wait_for(0, 2'b01);
        wait_for(0, 2'b00);
        @(posedge ref_clk);
        #1;
        check("op_mode ignores bits", 16'h3, op_mode);

        // soft reset keeps the led setting, hard reset clears it
        wr(5'h00, 16'h8000);
        repeat (2) @(posedge ref_clk);
        #1;
        check("an_run soft", 16'h1, an_run);
        rd(5'h00, rd_v);
        check("ctrl soft", 16'h3000, rd_v & 16'hB300);
        check("led kept", 16'h3, led_mode);
        do_reset();
        check("led hard", 16'h0, led_mode);
        give_verdict();
    end
endmodule // tb_top
